/* File: csc_channel.sv */
// One serial channel: setup registers, prescalers, slave shifter, irq.
// Assumes synchronous inputs and a register port with one-cycle strobes.
`timescale 1ns/1ps
`include "csc_cfg.svh"
module csc_channel #(
  parameter int DATA_W = 9
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [`CSC_ADDR_W-1:0] regAddr,
  input  wire logic [15:0]            regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [15:0]            regRdata,
  input  wire logic                   serialClockPin,
  input  wire logic                   serialDataIn,
  input  wire logic                   uartReceivePin,
  output logic                        serialDataOut,
  output logic                        chanEnableFlag,
  output logic                        irqOut,
  output logic      [1:0]             irqPrioLevel
);
  logic [15:0] modeReg;
  logic [15:0] commReg;
  logic [7:0]  prioLoReg;
  logic [7:0]  prioHiReg;
  logic [7:0]  prescaleReg;
  logic [2:0]  errFlagsReg;
  logic [`CSC_EV_W-1:0] irqStatReg;
  logic [`CSC_EV_W-1:0] irqEnReg;
  logic [DATA_W-1:0] txBufReg;
  logic        txFullReg;
  logic [DATA_W-1:0] rxBufReg;
  logic        rxFullReg;
  logic [DATA_W-1:0] shiftReg;
  logic [3:0]  bitCntReg;
  logic        sckPrevReg;
  logic        rxdPrevReg;
  logic [14:0] divCntReg;
  logic        tickReg;
  csc_pkg::csc_state_type stateReg;

  wire wrStop   = regWr && regAddr == `CSC_OFF_STOP;
  wire wrClr    = regWr && regAddr == `CSC_OFF_FLAGCLR;
  wire wrStart  = regWr && regAddr == `CSC_OFF_START && regWdata[0];
  wire wrTx     = regWr && regAddr == `CSC_OFF_TXDATA;
  wire rdRx     = regRd && regAddr == `CSC_OFF_RXDATA;
  wire txEnable = commReg[`CSC_TXE_BIT];
  wire rxEnable = commReg[`CSC_RXE_BIT];
  wire lsbFirst = commReg[`CSC_DIR_BIT];
  csc_pkg::csc_proto_type proto;
  assign proto = csc_pkg::csc_proto_type'(modeReg[`CSC_MD_HI:`CSC_MD_LO]);

  // Frame length: 11 eight, 10 seven, 00 nine (async only)
  logic [3:0] frameLen;
  always_comb begin
    unique case (commReg[1:0])
      2'h3: frameLen = 4'h8;
      2'h2: frameLen = 4'h7;
      2'h0: frameLen = (proto == csc_pkg::CSC_PROTO_ASYNC) ? 4'h9 : 4'h8;
      default: frameLen = 4'h8; // Prohibited code falls back to eight
    endcase
  end

  // Free-running divider; bit k toggling gives clk/2^(k+1) rate edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      divCntReg     <= 15'h0000;
    end else begin
      divCntReg     <= divCntReg + 15'h0001;
    end
  end

  // Selector s gives one pulse every 2^s cycles
  function automatic logic prescaleTick(input logic [3:0] sel,
                                        input logic [14:0] cnt);
    logic [15:0] mask;
    mask = (16'h0001 << sel) - 16'h0001;
    prescaleTick = (({1'b0, cnt} & mask) == 16'h0000);
  endfunction

  wire tickA = prescaleTick(prescaleReg[3:0], divCntReg);
  wire tickB = prescaleTick(prescaleReg[7:4], divCntReg);
  wire opTick = modeReg[`CSC_CKS_BIT] ? tickB : tickA;
  always_ff @(posedge clk) begin
    if (!nrst) tickReg <= 1'b0;
    else tickReg <= opTick;
  end

  // Slave clock edges come only from the master; internal clock is a
  // master-mode source and just paces the simple internal shift here
  wire sckRise  = serialClockPin && !sckPrevReg;
  wire sckFall  = !serialClockPin && sckPrevReg;
  wire useExt   = modeReg[`CSC_CCS_BIT];
  wire sampleEv = useExt ? sckRise : tickReg;
  wire shiftEv  = useExt ? sckFall : 1'b0;
  wire rxdFall  = !uartReceivePin && rxdPrevReg;
  wire startEv  = modeReg[`CSC_STS_BIT] ? rxdFall : wrStart;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sckPrevReg <= 1'b1;
      rxdPrevReg <= 1'b1;
    end else begin
      sckPrevReg <= serialClockPin;
      rxdPrevReg <= uartReceivePin;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      modeReg     <= `CSC_MODE_RST;
      commReg     <= `CSC_COMM_RST;
      prioLoReg   <= `CSC_PRIO_RST;
      prioHiReg   <= `CSC_PRIO_RST;
      prescaleReg <= 8'h00;
      irqEnReg    <= '0;
    end else if (regWr) begin
      unique case (regAddr)
        `CSC_OFF_MODE: begin
          // Prohibited protocol code is refused, old mode kept
          if (regWdata[`CSC_MD_HI:`CSC_MD_LO] != 2'h3) begin
            modeReg <= regWdata;
          end
        end
        `CSC_OFF_COMM:     commReg     <= regWdata;
        `CSC_OFF_PRIO_LO:  prioLoReg   <= regWdata[7:0];
        `CSC_OFF_PRIO_HI:  prioHiReg   <= regWdata[7:0];
        `CSC_OFF_PRESCALE: prescaleReg <= regWdata[7:0];
        `CSC_OFF_IRQEN:    irqEnReg    <= regWdata[`CSC_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Channel enable: start sets, stop trigger clears
  always_ff @(posedge clk) begin
    if (!nrst) chanEnableFlag <= 1'b0;
    else if (wrStop && regWdata[0]) chanEnableFlag <= 1'b0;
    else if (startEv) chanEnableFlag <= 1'b1;
  end

  // Transmit buffer
  logic txLoad;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txBufReg  <= '0;
      txFullReg <= 1'b0;
    end else if (wrTx) begin
      txBufReg  <= regWdata[DATA_W-1:0];
      txFullReg <= 1'b1;
    end else if (txLoad) begin
      txFullReg <= 1'b0;
    end
  end

  // Shifter
  logic frameDone;
  wire  active = chanEnableFlag && (txEnable || rxEnable);
  wire  lastBit = (bitCntReg == frameLen - 4'h1);
  assign txLoad = (stateReg == csc_pkg::CSC_ST_IDLE) && active && txFullReg;
  assign frameDone = (stateReg == csc_pkg::CSC_ST_SHIFT) && sampleEv
                     && lastBit;
  logic [DATA_W-1:0] txWord;
  assign txWord = txEnable ? txBufReg : '1;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stateReg      <= csc_pkg::CSC_ST_IDLE;
      shiftReg      <= '0;
      bitCntReg     <= 4'h0;
      serialDataOut <= 1'b1;
    end else if (!active) begin
      stateReg      <= csc_pkg::CSC_ST_IDLE;
      bitCntReg     <= 4'h0;
    end else begin
      unique case (stateReg)
        csc_pkg::CSC_ST_IDLE: begin
          bitCntReg <= 4'h0;
          if (txLoad || (rxEnable && !txEnable && sckFall)) begin
            stateReg      <= csc_pkg::CSC_ST_SHIFT;
            shiftReg      <= txWord;
            serialDataOut <= lsbFirst ? txWord[0]
                                      : txWord[frameLen - 4'h1];
          end
        end
        csc_pkg::CSC_ST_SHIFT: begin
          if (sampleEv) begin
            // Received bit enters at the end opposite the one the output drains from
            if (lsbFirst) begin
              shiftReg <= {1'b0, shiftReg[DATA_W-1:1]};
              shiftReg[frameLen - 4'h1] <= serialDataIn;
            end else begin
              shiftReg <= {shiftReg[DATA_W-2:0], serialDataIn};
            end
            bitCntReg <= bitCntReg + 4'h1;
            if (lastBit) stateReg <= csc_pkg::CSC_ST_DONE;
          end else if (shiftEv) begin
            serialDataOut <= lsbFirst ? shiftReg[0]
                                      : shiftReg[frameLen - 4'h1];
          end
        end
        csc_pkg::CSC_ST_DONE: stateReg <= csc_pkg::CSC_ST_IDLE;
      endcase
    end
  end

  // Receive buffer and overrun; new word beats a read in same cycle
  logic [DATA_W-1:0] rxWord;
  always_comb begin
    // Last bit is not yet in the shifter, so apply its shift here
    rxWord = {shiftReg[DATA_W-2:0], 1'b0};
    if (lsbFirst) rxWord = {1'b0, shiftReg[DATA_W-1:1]};
    rxWord[lsbFirst ? frameLen - 4'h1 : 4'h0] = serialDataIn;
  end
  wire rxStore = frameDone && rxEnable;
  wire overrun = rxStore && rxFullReg && !rdRx;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxBufReg  <= '0;
      rxFullReg <= 1'b0;
    end else if (rxStore) begin
      rxBufReg  <= rxWord;
      rxFullReg <= 1'b1;
    end else if (rdRx) begin
      rxFullReg <= 1'b0;
    end
  end

  // Error flags: hardware set wins over a clear in the same cycle.
  // Framing and parity are set only by async framing logic not built here.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      errFlagsReg <= 3'h0;
    end else begin
      if (wrClr && regWdata[`CSC_FE_BIT])
        errFlagsReg[`CSC_FE_BIT] <= 1'b0;
      if (wrClr && regWdata[`CSC_PE_BIT])
        errFlagsReg[`CSC_PE_BIT] <= 1'b0;
      if (overrun)
        errFlagsReg[`CSC_OV_BIT] <= 1'b1;
      else if (wrClr && regWdata[`CSC_OV_BIT])
        errFlagsReg[`CSC_OV_BIT] <= 1'b0;
    end
  end

  // Interrupt status: sticky, set beats write-one clear
  logic [`CSC_EV_W-1:0] events;
  always_comb begin
    events = '0;
    events[`CSC_EV_END]   = frameDone && !modeReg[`CSC_MDS_BIT];
    events[`CSC_EV_EMPTY] = txLoad && modeReg[`CSC_MDS_BIT];
    events[`CSC_EV_OVR]   = overrun;
  end
  always_ff @(posedge clk) begin
    if (!nrst) irqStatReg <= '0;
    else if (regWr && regAddr == `CSC_OFF_IRQCLR)
      irqStatReg <= (irqStatReg & ~regWdata[`CSC_EV_W-1:0]) | events;
    else irqStatReg <= irqStatReg | events;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqOut       <= 1'b0;
      irqPrioLevel <= 2'h3;
    end else begin
      irqOut       <= |(irqStatReg & irqEnReg);
      irqPrioLevel <= {prioLoReg[`CSC_PRIO_BIT],
                       prioHiReg[`CSC_PRIO_BIT]};
    end
  end

  // Read port: data stand one cycle after the strobe
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    unique case (regAddr)
      `CSC_OFF_PRIO_LO:  rdMux = {8'h00, prioLoReg};
      `CSC_OFF_PRIO_HI:  rdMux = {8'h00, prioHiReg};
      `CSC_OFF_MODE:     rdMux = modeReg;
      `CSC_OFF_COMM:     rdMux = commReg;
      `CSC_OFF_STATUS:   rdMux = {9'h000, txFullReg, rxFullReg,
                                  chanEnableFlag, 1'b0, errFlagsReg};
      `CSC_OFF_PRESCALE: rdMux = {8'h00, prescaleReg};
      `CSC_OFF_RXDATA:   rdMux = 16'(rxBufReg);
      `CSC_OFF_IRQSTAT:  rdMux = 16'(irqStatReg);
      `CSC_OFF_IRQEN:    rdMux = 16'(irqEnReg);
      `CSC_OFF_PRIO_LVL: rdMux = {14'h0000, irqPrioLevel};
      default:           rdMux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!nrst) regRdata <= 16'h0000;
    else if (regRd) regRdata <= rdMux;
    else regRdata <= 16'h0000;
  end
endmodule

/* File: csc_cfg.svh */
// Register offsets, field positions and reset values
// for the serial channel setup block. Included by the channel, checker and bench.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
`define CSC_ADDR_W        4
`define CSC_OFF_STOP      4'h0
`define CSC_OFF_PRIO_LO   4'h1
`define CSC_OFF_PRIO_HI   4'h2
`define CSC_OFF_FLAGCLR   4'h3
`define CSC_OFF_MODE      4'h4
`define CSC_OFF_COMM      4'h5
`define CSC_OFF_STATUS    4'h6
`define CSC_OFF_PRESCALE  4'h7
`define CSC_OFF_START     4'h8
`define CSC_OFF_TXDATA    4'h9
`define CSC_OFF_RXDATA    4'hA
`define CSC_OFF_IRQSTAT   4'hB
`define CSC_OFF_IRQEN     4'hC
`define CSC_OFF_IRQCLR    4'hD
`define CSC_OFF_PRIO_LVL  4'hE
`define CSC_PRIO_BIT      5
`define CSC_FE_BIT        2
`define CSC_PE_BIT        1
`define CSC_OV_BIT        0
`define CSC_CKS_BIT       15
`define CSC_CCS_BIT       14
`define CSC_STS_BIT       8
`define CSC_MD_HI         2
`define CSC_MD_LO         1
`define CSC_MDS_BIT       0
`define CSC_TXE_BIT       15
`define CSC_RXE_BIT       14
`define CSC_DIR_BIT       7
`define CSC_MODE_RST      16'h0020
`define CSC_COMM_RST      16'h0087
`define CSC_PRIO_RST      8'hFF
`define CSC_EV_END        0
`define CSC_EV_EMPTY      1
`define CSC_EV_OVR        2
`define CSC_EV_W          3
`endif

/* File: csc_pkg.sv */
// Types shared by the serial channel setup block.
// Assumes csc_cfg.svh is on the include path.
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_PROTO_CLOCKED = 2'h0,
    CSC_PROTO_ASYNC   = 2'h1,
    CSC_PROTO_TWOWIRE = 2'h2,
    CSC_PROTO_BAD     = 2'h3
  } csc_proto_type;
  typedef enum logic [2:0] {
    CSC_ST_IDLE  = 3'h1,
    CSC_ST_SHIFT = 3'h2,
    CSC_ST_DONE  = 3'h4
  } csc_state_type;
endpackage

/* File: csc_channel_sva.sv */
// Port checker for csc_channel, bound to every instance below.
// Assumes the register map and field positions of csc_cfg.svh.
`timescale 1ns/1ps
`include "csc_cfg.svh"
module csc_chk (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic [`CSC_ADDR_W-1:0] regAddr,
  input wire logic [15:0]            regWdata,
  input wire logic                   regWr,
  input wire logic                   regRd,
  input wire logic [15:0]            regRdata,
  input wire logic                   chanEnableFlag,
  input wire logic                   irqOut,
  input wire logic [1:0]             irqPrioLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [1:0] prio_reg;
  logic [1:0] quiet_reg;
  wire wrLo = regWr && regAddr == `CSC_OFF_PRIO_LO;
  wire wrHi = regWr && regAddr == `CSC_OFF_PRIO_HI;
  wire wrMode = regWr && regAddr == `CSC_OFF_MODE;
  wire rdMode = regRd && regAddr == `CSC_OFF_MODE;
  wire wrComm = regWr && regAddr == `CSC_OFF_COMM;
  wire rdComm = regRd && regAddr == `CSC_OFF_COMM;
  wire wrStop = regWr && regAddr == `CSC_OFF_STOP;
  // Level output lags the priority registers; judge it only once settled
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prio_reg <= 2'h3;
      quiet_reg <= 2'h0;
    end else begin
      if (wrLo) prio_reg[1] <= regWdata[`CSC_PRIO_BIT];
      if (wrHi) prio_reg[0] <= regWdata[`CSC_PRIO_BIT];
      if (wrLo || wrHi) quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
    end
  end
  a_rdata_one_cycle: assert property (regRdata != 16'h0 |-> $past(regRd))
    else $error("read data seen outside a read answer");
  a_unmapped_zero: assert property (regRd && regAddr == 4'hF
    |=> regRdata == 16'h0) else $error("unmapped read not zero");
  a_stop_clears: assert property (wrStop && regWdata[0]
    |-> ##[1:2] !chanEnableFlag) else $error("stop left channel on");
  a_prio_follows: assert property (quiet_reg >= 2'h2
    |-> irqPrioLevel == prio_reg) else $error("priority level wrong");
  a_mode_refused: assert property (wrMode && regWdata[2:1] == 2'h3
    ##1 rdMode |=> regRdata[2:1] != 2'h3) else $error("bad mode taken");
  a_mode_kept: assert property (
    wrMode && regWdata[2:1] != 2'h3 ##1 rdMode
    |=> (regRdata & 16'hC107) == ($past(regWdata, 2) & 16'hC107))
    else $error("mode readback wrong");
  a_comm_kept: assert property (wrComm ##1 rdComm
    |=> (regRdata & 16'hC083) == ($past(regWdata, 2) & 16'hC083))
    else $error("comm readback wrong");
  a_flags_cleared: assert property (
    regWr && regAddr == `CSC_OFF_FLAGCLR
    && regWdata[2:0] == 3'h7 ##1 regRd && regAddr == `CSC_OFF_STATUS
    |=> regRdata[2:0] == 3'h0) else $error("error flags not cleared");
  a_irq_masked: assert property (regWr && regAddr == `CSC_OFF_IRQEN
    && regWdata == 16'h0 |=> ##1 !irqOut) else $error("masked irq high");
  cover property (wrStop && regWdata[0] && chanEnableFlag);
  cover property ($rose(irqOut));
  cover property (wrMode && regWdata[2:1] == 2'h3);
endmodule
bind csc_channel csc_chk i_chk (.clk(clk), .nrst(nrst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .chanEnableFlag(chanEnableFlag), .irqOut(irqOut),
  .irqPrioLevel(irqPrioLevel));

/* File: csc_master_model.sv */
// Serial master model: clocks one 8-bit frame per go pulse.
// Assumes the slave samples on the rising clock and shifts on the falling.
`timescale 1ns/1ps
module csc_master_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] txWord,
  input  wire logic       lsbFirst,
  input  wire logic       slow,
  input  wire logic       slaveOut,
  output logic            sck,
  output logic            mosi,
  output logic [7:0]      rxWord,
  output logic            busy
);
  int half;
  initial begin
    sck = 1'b1;
    mosi = 1'b1;
    rxWord = 8'h00;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        half = slow ? 9 : 3;
        for (int i = 0; i < 8; i++) begin
          repeat (half) @(posedge clk);
          sck <= 1'b0;
          mosi <= txWord[lsbFirst ? i : 7 - i];
          repeat (half) @(posedge clk);
          sck <= 1'b1;
          rxWord <= lsbFirst ? {slaveOut, rxWord[7:1]}
                             : {rxWord[6:0], slaveOut};
        end
        repeat (half) @(posedge clk);
        // Line is driven to the inverse of the last bit so no stale bit shows; clock stands high between frames
        mosi <= ~mosi;
        busy <= 1'b0;
      end
    end
  end
endmodule

/* File: test_csi_slave_channel_setup.sv */
// Self-checking bench for the serial channel setup block.
// Drives the register port and a serial master model; reads are queued.
`timescale 1ns/1ps
`include "csc_cfg.svh"
module test_csi_slave_channel_setup;
  typedef struct {logic [15:0] v; logic [15:0] m;} csc_exp_type;
  logic        clk, nrst, regWr, regRd, go, lsbFirst, slow, uartRx;
  logic        rdLast, sck, mosi, sdo, en, irq, mBusy;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, w, c;
  logic [7:0]  b, mTx, mRx;
  logic [1:0]  prio;
  csc_exp_type expQ[$];
  csc_exp_type e;
  int          miscompares, nChecks, t;
  csc_channel i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .serialClockPin(sck), .serialDataIn(mosi), .uartReceivePin(uartRx),
    .serialDataOut(sdo), .chanEnableFlag(en), .irqOut(irq),
    .irqPrioLevel(prio));
  csc_master_model i_master (.clk(clk), .go(go), .txWord(mTx),
    .lsbFirst(lsbFirst), .slow(slow), .slaveOut(sdo), .sck(sck),
    .mosi(mosi), .rxWord(mRx), .busy(mBusy));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] x,
                     input logic [15:0] g);
    nChecks++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cyc(input logic wr, input logic rd, input logic [3:0] a,
                     input logic [15:0] d);
    regWr <= wr;
    regRd <= rd;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] v,
                    input logic [15:0] m);
    expQ.push_back('{v & m, m});
    cyc(1'b0, 1'b1, a, 16'h0);
  endtask
  task automatic idle(input int n);
    cyc(1'b0, 1'b0, 4'h0, 16'h0);
    repeat (n - 1) @(posedge clk);
  endtask
  task automatic xfer(input logic s);
    b = $urandom;
    cyc(1'b1, 1'b0, `CSC_OFF_TXDATA, {8'h0, b});
    mTx <= $urandom;
    slow <= s;
    go <= 1'b1;
    idle(1);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (t = 0; t < 500 && mBusy !== 1'b0; t++) @(posedge clk);
    idle(4);
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Read answers stand for one cycle only, so compare mid-cycle
  always @(posedge clk) rdLast <= regRd;
  always @(negedge clk) begin
    if (rdLast === 1'b1) begin
      e = expQ.pop_front();
      chk("regRdata", e.v, regRdata & e.m);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial begin
    {nrst, regWr, regRd, go, lsbFirst, slow, regAddr, regWdata} = '0;
    {uartRx, mTx} = 9'h100;
    t = $urandom(1040);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    idle(1);
    rd(`CSC_OFF_MODE, `CSC_MODE_RST, 16'hFFFF);
    rd(`CSC_OFF_COMM, `CSC_COMM_RST, 16'hFFFF);
    rd(`CSC_OFF_PRIO_LO, 16'h00FF, 16'h00FF);
    rd(`CSC_OFF_PRIO_HI, 16'h00FF, 16'h00FF);
    idle(2);
    chk("irqPrioLevel", 16'h3, {14'h0, prio});
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      w = ($urandom & 16'hC101) | 16'h0020 | 16'((i % 3) * 2);
      cyc(1'b1, 1'b0, `CSC_OFF_MODE, w);
      rd(`CSC_OFF_MODE, w, 16'hC107);
      cyc(1'b1, 1'b0, `CSC_OFF_MODE, w | 16'h0006);
      rd(`CSC_OFF_MODE, w, 16'hC107);
      c = ($urandom & 16'hC080) | 16'h0004 | (i[0] ? 16'h2 : 16'h3);
      cyc(1'b1, 1'b0, `CSC_OFF_COMM, c);
      rd(`CSC_OFF_COMM, c, 16'hC083);
      cyc(1'b1, 1'b0, `CSC_OFF_PRIO_LO, {10'h0, i[1], 5'h0});
      cyc(1'b1, 1'b0, `CSC_OFF_PRIO_HI, {10'h0, i[0], 5'h0});
      idle(3);
      chk("irqPrioLevel", {14'h0, i[1], i[0]}, {14'h0, prio});
    end
    $display("test register fields done");
    for (int k = 0; k < 2; k++) begin
      lsbFirst <= k[0];
      cyc(1'b1, 1'b0, `CSC_OFF_MODE, 16'h4020);
      cyc(1'b1, 1'b0, `CSC_OFF_COMM, {8'hC0, k[0], 7'h07});
      cyc(1'b1, 1'b0, `CSC_OFF_IRQEN, 16'h0001);
      cyc(1'b1, 1'b0, `CSC_OFF_START, 16'h0001);
      rd(`CSC_OFF_STATUS, 16'h0010, 16'h0010);
      xfer(k[0]);
      chk("master rx", {8'h0, b}, {8'h0, mRx});
      chk("irqOut", 16'h1, {15'h0, irq});
      rd(`CSC_OFF_RXDATA, {8'h0, mTx}, 16'h00FF);
      rd(`CSC_OFF_IRQSTAT, 16'h0001, 16'h0001);
      cyc(1'b1, 1'b0, `CSC_OFF_IRQEN, 16'h0000);
      idle(3);
      chk("irqOut masked", 16'h0, {15'h0, irq});
      cyc(1'b1, 1'b0, `CSC_OFF_IRQCLR, 16'h0001);
      cyc(1'b1, 1'b0, `CSC_OFF_IRQEN, 16'h0001);
      idle(3);
      chk("irqOut cleared", 16'h0, {15'h0, irq});
    end
    $display("test serial frames done");
    xfer(1'b0);
    xfer(1'b0);
    rd(`CSC_OFF_STATUS, 16'h0001, 16'h0001);
    rd(`CSC_OFF_IRQSTAT, 16'h0004, 16'h0004);
    cyc(1'b1, 1'b0, `CSC_OFF_FLAGCLR, 16'h0000);
    rd(`CSC_OFF_STATUS, 16'h0001, 16'h0001);
    cyc(1'b1, 1'b0, `CSC_OFF_FLAGCLR, 16'h0007);
    rd(`CSC_OFF_STATUS, 16'h0000, 16'h0007);
    cyc(1'b1, 1'b0, `CSC_OFF_MODE, 16'h4021);
    cyc(1'b1, 1'b0, `CSC_OFF_TXDATA, 16'h00A5);
    idle(2);
    rd(`CSC_OFF_IRQSTAT, 16'h0002, 16'h0002);
    $display("test overrun done");
    cyc(1'b1, 1'b0, `CSC_OFF_STOP, 16'h0000);
    idle(2);
    chk("chanEnableFlag", 16'h1, {15'h0, en});
    cyc(1'b1, 1'b0, `CSC_OFF_STOP, 16'h0001);
    idle(2);
    chk("chanEnableFlag", 16'h0, {15'h0, en});
    rd(4'hF, 16'h0000, 16'hFFFF);
    cyc(1'b1, 1'b0, `CSC_OFF_MODE, 16'h4120);
    idle(1);
    uartRx <= 1'b0;
    idle(6);
    chk("chanEnableFlag", 16'h1, {15'h0, en});
    uartRx <= 1'b1;
    idle(2);
    $display("test stop and pin start done");
    complete_run();
  end
endmodule
